/* src/qsca_pkg.sv */
// How it works
// [RULE1] Four channels with separate logic, straps and output pulses.
// [RULE2] Integral mode: every lower crossing yields a window-hit pulse.
// [RULE3] Normal mode: hit only if upper never crossed during the pulse.
// [RULE4] Window mode: hit only if upper comparator at lower plus width stays quiet.
// [RULE5] Mode from two straps: integral, normal, or window when first strap is set.
// [RULE6] Window-hit pulse fires as the pulse falls back below lower level.
// [RULE7] User must set upper level above lower level in normal mode.
// [RULE8] Lower-crossing pulse fires on the leading edge crossing the lower level.
// [RULE9] Upper-crossing pulse fires on the leading edge crossing the upper level.
// [RULE10] Lower and upper crossing outputs work in every mode.
// [RULE11] All three outputs are positive pulses 500 ns wide.
// [RULE12] Second pulse resolved 200 ns plus one pulse width after the first.
// [RULE13] Integral mode ignores the upper level for the hit decision.
// [RULE14] Per-channel strap picks panel or rear bias as lower threshold source.
// [RULE15] Thresholds 20 mV to 9.99 V; window width 2 mV to 0.999 V.
// [RULE16] Channel button steps meter over channels 1 to 4, red indicator shows it.
// [RULE17] Level button toggles lower or upper reading, yellow indicator shows it.
// [RULE18] Meter display flashes when the value is above its range.
// [RULE19] Reader divides the meter value by 10 in window mode.
// [RULE20] Crossings synchronised; widths and dead time counted in clock cycles.
// [RULE21] Lower crossings during dead time are ignored and give no outputs.
package qsca_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_WIDTH_NS = 500;
    localparam int RESOLVE_NS = 200;
    localparam int FLASH_HALF_MS = 250;
    localparam int PULSE_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CYC = (RESOLVE_NS + PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;

    // Channel count and meter range, meter codes in 10 mV steps
    localparam int NUM_CHAN = 4;
    localparam int METER_W = 12;
    localparam logic [11:0] METER_MIN_CODE = 12'h002;
    localparam logic [11:0] METER_MAX_CODE = 12'h3E7;

    // Register offsets (byte addresses)
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // Configuration register layout and reset
    localparam int STRAP_BITS = 3;
    localparam logic [11:0] CFG_RESET = 12'h000;

    // Status register layout
    localparam int ST_CHAN_LSB = 0;
    localparam int ST_UPPER_BIT = 2;
    localparam int ST_OVER_BIT = 3;
    localparam int ST_MODE_LSB = 4;

    typedef enum logic [1:0] {
        MODE_INTEGRAL,
        MODE_NORMAL,
        MODE_WINDOW
    } qsca_mode_t;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_ABOVE,
        CH_DEAD
    } qsca_chan_state_t;

    // Strap group of one channel, low bit is mode_strap_a
    typedef struct packed {
        logic low_threshold_source_strap;
        logic mode_strap_b;
        logic mode_strap_a;
    } qsca_strap_t;

    // Strap decode, shared by channel logic and status read
    function automatic qsca_mode_t decode_mode(input qsca_strap_t s);
        qsca_mode_t m;
        if (s.mode_strap_a) begin
            m = MODE_WINDOW;
        end else if (s.mode_strap_b) begin
            m = MODE_NORMAL;
        end else begin
            m = MODE_INTEGRAL;
        end
        return m;
    endfunction

endpackage

/* src/qsca_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module qsca_sync #(
    parameter int W = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // First stage feeds only the second stage
    always_comb begin
        next_s = s;
        next_s.meta = d_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign q_out = s.stable;
endmodule
`default_nettype wire

/* src/qsca_pulse.sv */
`timescale 1ns/10ps
`default_nettype none
module qsca_pulse #(
    parameter int N = 12,
    parameter int WIDTH = qsca_pkg::PULSE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [N-1:0] fire_in,
    output logic [N-1:0] pulse_out
);
    localparam int CW = $clog2(WIDTH + 1);
    localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

    typedef struct packed {
        logic [N-1:0] active;
        logic [N-1:0][CW-1:0] cnt;
    } pulse_state_t;

    pulse_state_t s;
    pulse_state_t next_s;

    // Fixed-width one-shots; a fire during a running pulse is dropped
    always_comb begin
        next_s = s;
        for (int i = 0; i < N; i++) begin
            if (!s.active[i]) begin
                if (fire_in[i]) begin
                    next_s.active[i] = 1'b1;
                    next_s.cnt[i] = LAST;
                end
            end else if (s.cnt[i] == '0) begin
                next_s.active[i] = 1'b0;
            end else begin
                next_s.cnt[i] = s.cnt[i] - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign pulse_out = s.active;
endmodule
`default_nettype wire

/* src/qsca_top.sv */
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module qsca_top #(
    parameter int NC = qsca_pkg::NUM_CHAN,
    parameter int DEAD = qsca_pkg::DEAD_CYC,
    parameter int FLASH_HALF = qsca_pkg::FLASH_HALF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Comparator levels from the analog front end
    input wire logic [NC-1:0] lower_discriminator_in,
    input wire logic [NC-1:0] upper_discriminator_in,
    // Logic pulse outputs
    output logic [NC-1:0] window_hit_output_out,
    output logic [NC-1:0] lower_crossing_output_out,
    output logic [NC-1:0] upper_crossing_output_out,
    // Analog steering from straps
    output logic [NC-1:0] rear_low_bias_select_out,
    output logic [NC-1:0] window_ref_select_out,
    // Voltmeter panel
    input wire logic chan_button_in,
    input wire logic level_button_in,
    input wire logic [qsca_pkg::METER_W-1:0] meter_code_in,
    output logic [1:0] meter_chan_out,
    output logic meter_upper_out,
    output logic [NC-1:0] chan_led_out,
    output logic level_led_out,
    output logic display_blank_out,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    localparam int DW = $clog2(DEAD + 1);
    localparam int FW = $clog2(FLASH_HALF + 1);
    localparam logic [DW-1:0] DEAD_LOAD = DW'(DEAD - 1);
    localparam logic [FW-1:0] FLASH_LOAD = FW'(FLASH_HALF - 1);
    localparam int STRAPW = NC * qsca_pkg::STRAP_BITS;

    typedef struct packed {
        logic [NC-1:0] lo_prev;
        logic [NC-1:0] up_prev;
        qsca_pkg::qsca_chan_state_t [NC-1:0] st;
        logic [NC-1:0] up_seen;
        logic [NC-1:0][DW-1:0] dead;
        qsca_pkg::qsca_strap_t [NC-1:0] straps;
        logic [1:0] mchan;
        logic mupper;
        logic chan_btn_prev;
        logic level_btn_prev;
        logic [FW-1:0] flash_cnt;
        logic blank;
        logic ack;
        logic [31:0] rdata;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;

    logic [NC-1:0] lo_sync;
    logic [NC-1:0] up_sync;
    logic [NC-1:0] fire_lo;
    logic [NC-1:0] fire_up;
    logic [NC-1:0] fire_hit;
    logic [3*NC-1:0] pulses;
    logic req;
    logic over;

    // [RULE20] synchronised comparator levels
    qsca_sync #(
        .W(2 * NC)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .d_in({upper_discriminator_in, lower_discriminator_in}),
        .q_out({up_sync, lo_sync})
    );

    // [RULE11] fixed-width one-shots
    qsca_pulse #(
        .N(3 * NC),
        .WIDTH(qsca_pkg::PULSE_CYC)
    ) u_pulse (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .fire_in({fire_hit, fire_up, fire_lo}),
        .pulse_out(pulses)
    );

    assign lower_crossing_output_out = pulses[NC-1:0];
    assign upper_crossing_output_out = pulses[2*NC-1:NC];
    assign window_hit_output_out = pulses[3*NC-1:2*NC];

    // Bus request and meter overrange
    assign req = avs_read_in | avs_write_in;
    // [RULE15] codes above 9.99 V full scale
    assign over = meter_code_in > qsca_pkg::METER_MAX_CODE;
    assign avs_waitrequest_out = req & ~(s.ack & ce_in);

    // Per-channel analysis, fires derived from current state
    always_comb begin
        fire_lo = '0;
        fire_up = '0;
        fire_hit = '0;
        // [RULE1] channels evaluated independently
        for (int i = 0; i < NC; i++) begin
            case (s.st[i])
                qsca_pkg::CH_IDLE: begin
                    // [RULE8] [RULE10] leading-edge lower crossing
                    fire_lo[i] = lo_sync[i] & ~s.lo_prev[i];
                end
                qsca_pkg::CH_ABOVE: begin
                    // [RULE9] [RULE10] leading-edge upper crossing, any mode
                    fire_up[i] = up_sync[i] & ~s.up_prev[i] & ~s.up_seen[i];
                    // [RULE6] hit launched as pulse falls below lower level
                    if (!lo_sync[i]) begin
                        case (qsca_pkg::decode_mode(s.straps[i]))
                            qsca_pkg::MODE_INTEGRAL: begin
                                // [RULE2] [RULE13] upper level ignored
                                fire_hit[i] = 1'b1;
                            end
                            qsca_pkg::MODE_NORMAL: begin
                                // [RULE3] no upper crossing allowed
                                fire_hit[i] = ~s.up_seen[i] & ~up_sync[i];
                            end
                            default: begin
                                // [RULE4] upper comparator sits at lower plus width
                                fire_hit[i] = ~s.up_seen[i] & ~up_sync[i];
                            end
                        endcase
                    end
                end
                default: begin
                    // [RULE21] crossings in dead time give nothing
                    fire_lo[i] = 1'b0;
                end
            endcase
        end
    end

    // Next-state logic for channels, panel and bus
    always_comb begin
        next_s = s;
        next_s.lo_prev = lo_sync;
        next_s.up_prev = up_sync;
        next_s.ack = 1'b0;

        for (int i = 0; i < NC; i++) begin
            case (s.st[i])
                qsca_pkg::CH_IDLE: begin
                    if (fire_lo[i]) begin
                        next_s.st[i] = qsca_pkg::CH_ABOVE;
                        next_s.up_seen[i] = 1'b0;
                    end
                end
                qsca_pkg::CH_ABOVE: begin
                    // Remember any upper crossing during this pulse
                    if (up_sync[i]) begin
                        next_s.up_seen[i] = 1'b1;
                    end
                    // [RULE12] dead time of resolve plus pulse width
                    if (!lo_sync[i]) begin
                        next_s.st[i] = qsca_pkg::CH_DEAD;
                        next_s.dead[i] = DEAD_LOAD;
                    end
                end
                default: begin
                    // [RULE21] hold off new crossings until count ends
                    if (s.dead[i] == '0) begin
                        next_s.st[i] = qsca_pkg::CH_IDLE;
                    end else begin
                        next_s.dead[i] = s.dead[i] - 1'b1;
                    end
                end
            endcase
        end

        // [RULE16] step meter channel on button press
        next_s.chan_btn_prev = chan_button_in;
        if (chan_button_in && !s.chan_btn_prev) begin
            next_s.mchan = s.mchan + 2'h1;
        end
        // [RULE17] toggle lower or upper reading
        next_s.level_btn_prev = level_button_in;
        if (level_button_in && !s.level_btn_prev) begin
            next_s.mupper = ~s.mupper;
        end

        // [RULE18] blink while over range, steady otherwise
        if (!over) begin
            next_s.blank = 1'b0;
            next_s.flash_cnt = FLASH_LOAD;
        end else if (s.flash_cnt == '0) begin
            next_s.blank = ~s.blank;
            next_s.flash_cnt = FLASH_LOAD;
        end else begin
            next_s.flash_cnt = s.flash_cnt - 1'b1;
        end

        // One wait cycle, then answer; write lands on the released edge
        if (req && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.rdata = '0;
            if (avs_address_in == qsca_pkg::ADDR_CFG) begin
                next_s.rdata[STRAPW-1:0] = s.straps;
            end else if (avs_address_in == qsca_pkg::ADDR_STATUS) begin
                next_s.rdata = status_word(s, over);
            end
        end
        // [RULE5] [RULE14] straps written by software
        if (avs_write_in && s.ack && avs_address_in == qsca_pkg::ADDR_CFG) begin
            if (avs_byteenable_in[0]) begin
                next_s.straps = straps_lane(s.straps, avs_writedata_in, 0);
            end
            if (avs_byteenable_in[1]) begin
                next_s.straps = straps_lane(next_s.straps, avs_writedata_in, 1);
            end
        end
    end

    // Merge one byte lane of write data into the strap field
    function automatic logic [STRAPW-1:0] straps_lane(input logic [STRAPW-1:0] old,
                                                      input logic [31:0] wd,
                                                      input int lane);
        logic [STRAPW-1:0] r;
        r = old;
        for (int b = 0; b < STRAPW; b++) begin
            if (b / 8 == lane) begin
                r[b] = wd[b];
            end
        end
        return r;
    endfunction

    // Status word assembly
    function automatic logic [31:0] status_word(input top_state_t t, input logic ov);
        logic [31:0] w;
        w = '0;
        w[qsca_pkg::ST_CHAN_LSB +: 2] = t.mchan;
        w[qsca_pkg::ST_UPPER_BIT] = t.mupper;
        w[qsca_pkg::ST_OVER_BIT] = ov;
        for (int i = 0; i < NC; i++) begin
            w[qsca_pkg::ST_MODE_LSB + 2 * i +: 2] = qsca_pkg::decode_mode(t.straps[i]);
        end
        return w;
    endfunction

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
            s.straps <= qsca_pkg::CFG_RESET;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    // Analog steering straight from straps
    always_comb begin
        for (int i = 0; i < NC; i++) begin
            // [RULE14] rear bias replaces panel setting
            rear_low_bias_select_out[i] = s.straps[i].low_threshold_source_strap;
            // [RULE4] upper comparator referenced to lower level
            window_ref_select_out[i] =
                qsca_pkg::decode_mode(s.straps[i]) == qsca_pkg::MODE_WINDOW;
        end
    end

    // Panel indicators
    always_comb begin
        chan_led_out = '0;
        chan_led_out[s.mchan] = 1'b1;
    end
    assign meter_chan_out = s.mchan;
    assign meter_upper_out = s.mupper;
    assign level_led_out = s.mupper;
    assign display_blank_out = s.blank;
    assign avs_readdata_out = s.rdata;
endmodule
`default_nettype wire

/* test/qsca_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module qsca_top_sva #(
    parameter int NC = 4,
    parameter int DEAD = 70,
    parameter int FLASH_HALF = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [NC-1:0] lower_discriminator_in,
    input wire logic [NC-1:0] upper_discriminator_in,
    input wire logic [NC-1:0] window_hit_output_out,
    input wire logic [NC-1:0] lower_crossing_output_out,
    input wire logic [NC-1:0] upper_crossing_output_out,
    input wire logic chan_button_in,
    input wire logic level_button_in,
    input wire logic [qsca_pkg::METER_W-1:0] meter_code_in,
    input wire logic [1:0] meter_chan_out,
    input wire logic meter_upper_out,
    input wire logic [NC-1:0] chan_led_out,
    input wire logic level_led_out,
    input wire logic display_blank_out,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out
);
    // One clock domain, so clock and reset are given once
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Crossing pulses follow a recent comparator rise, not a stale level
    a_lowx_lead: assert property ($rose(lower_crossing_output_out[0]) |->
        $past(lower_discriminator_in[0], 2) && !$past(lower_discriminator_in[0], 6))
        else $error("lower crossing pulse without a fresh lower rise");
    a_upx_lead: assert property ($rose(upper_crossing_output_out[1]) |->
        $past(upper_discriminator_in[1], 2) && !$past(upper_discriminator_in[1], 6))
        else $error("upper crossing pulse without a fresh upper rise");
    // Hit is launched by the trailing edge only
    a_hit_trail: assert property ($rose(window_hit_output_out[2]) |->
        !$past(lower_discriminator_in[2], 2) && $past(lower_discriminator_in[2], 6))
        else $error("hit pulse not caused by a lower fall");
    // Widths are exactly 50 cycles at 100 MHz
    a_hit_width: assert property ($fell(window_hit_output_out[0]) |->
        $past(window_hit_output_out[0], 50) && !$past(window_hit_output_out[0], 51))
        else $error("hit pulse width wrong");
    a_upx_width: assert property ($rose(upper_crossing_output_out[1]) |->
        ##49 upper_crossing_output_out[1] ##1 !upper_crossing_output_out[1])
        else $error("upper crossing pulse width wrong");
    // Indicators mirror the meter selection
    a_led_track: assert property (chan_led_out == NC'(1) << meter_chan_out &&
        level_led_out == meter_upper_out)
        else $error("indicator does not match selection");
    a_chan_step: assert property ($changed(meter_chan_out) |->
        meter_chan_out == $past(meter_chan_out) + 2'h1 &&
        ($past(chan_button_in) || $past(chan_button_in, 2)))
        else $error("channel selection moved wrongly");
    a_level_cause: assert property ($changed(meter_upper_out) |->
        $past(level_button_in) || $past(level_button_in, 2))
        else $error("level selection toggled without button");
    a_blank_cause: assert property ($rose(display_blank_out) |->
        $past(meter_code_in) > 12'h3E7 || $past(meter_code_in, 2) > 12'h3E7)
        else $error("display blanked while in range");
    a_bus_wait: assert property (($rose(avs_read_in) || $rose(avs_write_in)) |->
        avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("bus answer not after one wait cycle");

    // Main scenarios reached
    c_hit: cover property ($rose(window_hit_output_out[0]));
    c_upx: cover property ($rose(upper_crossing_output_out[3]));
    c_blank: cover property ($rose(display_blank_out));
endmodule

bind qsca_top qsca_top_sva #(.NC(NC), .DEAD(DEAD), .FLASH_HALF(FLASH_HALF)) u_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .lower_discriminator_in(lower_discriminator_in),
    .upper_discriminator_in(upper_discriminator_in),
    .window_hit_output_out(window_hit_output_out),
    .lower_crossing_output_out(lower_crossing_output_out),
    .upper_crossing_output_out(upper_crossing_output_out),
    .chan_button_in(chan_button_in), .level_button_in(level_button_in),
    .meter_code_in(meter_code_in), .meter_chan_out(meter_chan_out),
    .meter_upper_out(meter_upper_out), .chan_led_out(chan_led_out),
    .level_led_out(level_led_out), .display_blank_out(display_blank_out),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out)
);
`default_nettype wire

/* test/qsca_amp_model.sv */
`timescale 1ns/10ps
`default_nettype none
module qsca_amp_model (
    input wire logic clk_in,
    output logic [3:0] lower_out,
    output logic [3:0] upper_out
);
    // Baseline sits below both thresholds between pulses
    initial begin
        lower_out = 4'h0;
        upper_out = 4'h0;
    end

    // One shaped pulse per selected channel; top_cyc sets how long it dwells
    // upper above lower: fires only inside the lower crossing
    task automatic shape(input logic [3:0] chans, input logic [3:0] big, input int top_cyc);
        @(posedge clk_in);
        lower_out <= chans;
        repeat (4) @(posedge clk_in);
        upper_out <= big & chans;
        repeat (top_cyc) @(posedge clk_in);
        upper_out <= 4'h0;
        repeat (4) @(posedge clk_in);
        lower_out <= 4'h0;
    endtask
endmodule
`default_nettype wire

/* test/quad_pulse_height_window_logic_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module quad_pulse_height_window_logic_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic chan_b = 1'b0;
    logic lvl_b = 1'b0;
    logic [11:0] meter_code = 12'h000;
    logic [3:0] addr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] ben = 4'hF;
    wire [3:0] low_lvl, up_lvl, hit_x, lo_x, up_x, rear_sel, win_sel, led;
    wire [31:0] rdata;
    wire [1:0] m_chan;
    wire m_up, lvl_led, blank, wait_req;
    int err_total = 0;
    int n_checks = 0;
    int lo_n[4], up_n[4], hit_n[4], e_lo[4], e_up[4], e_hit[4];
    int blank_n = 0;
    logic [3:0] lo_q = 4'h0, up_q = 4'h0, hit_q = 4'h0;
    logic blank_q = 1'b0;
    int gaps[2] = '{20, 74};
    int extra[2] = '{1, 2};

    always #5 clk_in = ~clk_in;

    qsca_amp_model amp (.clk_in(clk_in), .lower_out(low_lvl), .upper_out(up_lvl));

    // Short blink period
    qsca_top #(.FLASH_HALF(8)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .lower_discriminator_in(low_lvl), .upper_discriminator_in(up_lvl),
        .window_hit_output_out(hit_x), .lower_crossing_output_out(lo_x),
        .upper_crossing_output_out(up_x), .rear_low_bias_select_out(rear_sel),
        .window_ref_select_out(win_sel), .chan_button_in(chan_b),
        .level_button_in(lvl_b), .meter_code_in(meter_code),
        .meter_chan_out(m_chan), .meter_upper_out(m_up), .chan_led_out(led),
        .level_led_out(lvl_led), .display_blank_out(blank),
        .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(ben),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req)
    );

    // Count rising edges where outputs are settled
    always @(negedge clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (lo_x[i] === 1'b1 && !lo_q[i]) lo_n[i]++;
            if (up_x[i] === 1'b1 && !up_q[i]) up_n[i]++;
            if (hit_x[i] === 1'b1 && !hit_q[i]) hit_n[i]++;
        end
        if (blank === 1'b1 && !blank_q) blank_n++;
        lo_q = lo_x;
        up_q = up_x;
        hit_q = hit_x;
        blank_q = blank;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        @(posedge clk_in);
        addr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= wd;
        ben <= be;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (wait_req !== 1'b0) begin
            err_total++;
            final_report();
        end else begin
            rd = rdata;
            rd_en <= 1'b0;
            wr_en <= 1'b0;
        end
    endtask

    task automatic wr32(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] unused;
        bus(1'b1, a, d, be, unused);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, 4'hF, v);
        check(v & mask, exp);
    endtask

    task automatic press(input logic lvl);
        @(posedge clk_in);
        if (lvl) lvl_b <= 1'b1;
        else chan_b <= 1'b1;
        repeat (3) @(posedge clk_in);
        lvl_b <= 1'b0;
        chan_b <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    // All twelve edge counts
    task automatic chk_counts();
        for (int i = 0; i < 4; i++) begin
            check(32'(lo_n[i]), 32'(e_lo[i]));
            check(32'(up_n[i]), 32'(e_up[i]));
            check(32'(hit_n[i]), 32'(e_hit[i]));
        end
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            lo_n[i] = 0; up_n[i] = 0; hit_n[i] = 0;
            e_lo[i] = 0; e_up[i] = 0; e_hit[i] = 0;
        end
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        // Reset state
        check(32'(led), 32'h1);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h0);
        rd_chk(4'h4, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        // Straps: ch0 integral, ch1 normal, ch2 window, ch3 normal with rear bias
        wr32(4'h0, 32'h00000C50, 4'hF);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000C50);
        rd_chk(4'h4, 32'h00000FF0, 32'h00000640);
        check(32'(rear_sel), 32'h8);
        check(32'(win_sel), 32'h4);
        wr32(4'h8, 32'hFFFFFFFF, 4'hF);
        rd_chk(4'h8, 32'hFFFFFFFF, 32'h0);
        wr32(4'h0, 32'hFFFFFFFF, 4'h2);
        rd_chk(4'h0, 32'hFFFFFFFF, 32'h00000F50);
        wr32(4'h0, 32'h00000C50, 4'hF);
        $display("test straps done");
        // Large pulse on every channel, then one that stays below upper
        amp.shape(4'hF, 4'hF, 10);
        repeat (100) @(posedge clk_in);
        for (int i = 0; i < 4; i++) begin
            e_lo[i]++;
            e_up[i]++;
        end
        e_hit[0]++;
        chk_counts();
        amp.shape(4'hF, 4'h0, 10);
        repeat (100) @(posedge clk_in);
        for (int i = 0; i < 4; i++) begin
            e_lo[i]++;
            e_hit[i]++;
        end
        chk_counts();
        $display("test modes done");
        // Pulse pair inside and just beyond the resolving time
        for (int g = 0; g < 2; g++) begin
            amp.shape(4'h1, 4'h0, 5);
            repeat (gaps[g]) @(posedge clk_in);
            amp.shape(4'h1, 4'h0, 5);
            repeat (120) @(posedge clk_in);
            e_lo[0] += extra[g];
            e_hit[0] += extra[g];
            chk_counts();
        end
        $display("test resolve done");
        // Meter selection wraps after the fourth channel
        for (int k = 1; k < 6; k++) begin
            press(1'b0);
            check(32'(m_chan), 32'(k % 4));
            check(32'(led), 32'(4'h1 << (k % 4)));
        end
        press(1'b1);
        check(32'(m_up), 32'h1);
        check(32'(lvl_led), 32'h1);
        rd_chk(4'h4, 32'h7, 32'h5);
        meter_code <= 12'h3E8;
        repeat (40) @(posedge clk_in);
        rd_chk(4'h4, 32'h8, 32'h8);
        check(32'(blank_n != 0), 32'h1);
        meter_code <= 12'h3E7;
        repeat (20) @(posedge clk_in);
        rd_chk(4'h4, 32'h8, 32'h0);
        $display("test meter done");
        final_report();
    end
endmodule
`default_nettype wire
